// *** verilog/pdx_detector_regs.sv ***
// Detector control and exact-frequency register bank with its decoded control outputs.
`timescale 1ns/10ps
`default_nettype none
`include "pdx_defines.svh"
module pdx_detector_regs (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [23:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [23:0] rdata_o,
    output logic [2:0] detector_reset_delay_select_o,
    output logic detector_inputs_short_o,
    output logic detector_polarity_invert_o,
    output logic detector_up_output_enable_o,
    output logic detector_down_output_enable_o,
    output logic [1:0] cycle_slip_guard_select_o,
    output logic [15:0] cycle_slip_threshold_cycles_o,
    output logic pump_force_up_o,
    output logic pump_force_down_o,
    output logic pump_mid_rail_o,
    output logic [1:0] main_divider_clock_gating_o,
    output logic exact_enable_o,
    output logic exact_wrap_o
);
    // Threshold times in comparator clock cycles, rounded up as least times.
    localparam logic [15:0] CSP1_CYC = 16'((`PDX_CSP1_PS + `PDX_CLK_PS - 1) / `PDX_CLK_PS);
    localparam logic [15:0] CSP2_CYC = 16'((`PDX_CSP2_PS + `PDX_CLK_PS - 1) / `PDX_CLK_PS);
    localparam logic [15:0] CSP3_CYC = 16'((`PDX_CSP3_PS + `PDX_CLK_PS - 1) / `PDX_CLK_PS);

    logic [23:0] det_q;
    logic [23:0] det_d;
    logic [23:0] exact_q;
    logic [23:0] exact_d;
    logic [23:0] rdata_q;
    logic [23:0] rdata_d;
    logic [21:0] ctl_q;
    logic [21:0] ctl_d;
    logic [15:0] csp_cyc_q;
    logic [15:0] csp_cyc_d;
    logic en_q;
    logic en_d;
    logic wrap_q;
    pdx_regif rif ();

    // Returns whether a channel count actually turns correction on.
    function automatic logic chan_valid(input logic [13:0] n);
        chan_valid = n >= `PDX_CHAN_MIN;
    endfunction : chan_valid

    // Maps the slip-guard code onto a cycle count; zero means disabled.
    function automatic logic [15:0] csp_cycles(input logic [1:0] code);
        case (pdx_pkg::pdx_csp_type'(code))
            pdx_pkg::PDX_CSP_T1: csp_cycles = CSP1_CYC;
            pdx_pkg::PDX_CSP_T2: csp_cycles = CSP2_CYC;
            pdx_pkg::PDX_CSP_T3: csp_cycles = CSP3_CYC;
            default: csp_cycles = 16'h0000;
        endcase
    endfunction : csp_cycles

    // Register writes; reserved bits of the detector word are stored as written.
    always_comb begin
        det_d = det_q;
        exact_d = exact_q;
        if (wr_i && addr_i == `PDX_OFS_DET) begin
            det_d = wdata_i & `PDX_DET_WMASK;
        end
        if (wr_i && addr_i == `PDX_OFS_EXACT) begin
            exact_d = wdata_i & `PDX_EXACT_WMASK;
        end
    end

    // Read mux; unmapped addresses answer with zero.
    always_comb begin
        rdata_d = 24'h000000;
        if (rd_i) begin
            case (addr_i)
                `PDX_OFS_DET: rdata_d = det_q;
                `PDX_OFS_EXACT: rdata_d = exact_q;
                `PDX_OFS_STATUS: rdata_d = {9'h000, en_q, rif.phase};
                default: rdata_d = 24'h000000;
            endcase
        end
    end

    // Field decode into registered outputs, so every control pin comes from a flip-flop.
    always_comb begin
        ctl_d[2:0] = det_q[`PDX_F_DELAY_MSB:`PDX_F_DELAY_LSB];
        ctl_d[3] = det_q[`PDX_F_SHORT];
        ctl_d[4] = det_q[`PDX_F_INVERT];
        ctl_d[5] = det_q[`PDX_F_UP_EN];
        ctl_d[6] = det_q[`PDX_F_DN_EN];
        ctl_d[8:7] = det_q[`PDX_F_CSP_MSB:`PDX_F_CSP_LSB];
        ctl_d[9] = det_q[`PDX_F_FORCE_UP];
        ctl_d[10] = det_q[`PDX_F_FORCE_DN];
        ctl_d[11] = det_q[`PDX_F_MID_RAIL];
        ctl_d[13:12] = det_q[`PDX_F_GATE_MSB:`PDX_F_GATE_LSB];
        ctl_d[21:14] = 8'h00;
        csp_cyc_d = csp_cycles(det_q[`PDX_F_CSP_MSB:`PDX_F_CSP_LSB]);
        en_d = chan_valid(exact_q[`PDX_F_CHAN_MSB:0]);
    end

    // Storage; the reset values are the documented defaults.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            det_q <= `PDX_RST_DET;
            exact_q <= `PDX_RST_EXACT;
            rdata_q <= 24'h000000;
            ctl_q <= 22'h003061;
            csp_cyc_q <= 16'h0000;
            en_q <= 1'b0;
            wrap_q <= 1'b0;
        end else begin
            det_q <= det_d;
            exact_q <= exact_d;
            rdata_q <= rdata_d;
            ctl_q <= ctl_d;
            csp_cyc_q <= csp_cyc_d;
            en_q <= en_d;
            wrap_q <= rif.wrap_pulse;
        end
    end

    assign rif.chan_count = exact_q[`PDX_F_CHAN_MSB:0];
    assign rif.enable = en_q;

    // The sequencer keeps the comparison-cycle phase for exact-frequency correction.
    pdx_exact_core u_core (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .rif(rif)
    );

    assign rdata_o = rdata_q;
    assign detector_reset_delay_select_o = ctl_q[2:0];
    assign detector_inputs_short_o = ctl_q[3];
    assign detector_polarity_invert_o = ctl_q[4];
    assign detector_up_output_enable_o = ctl_q[5];
    assign detector_down_output_enable_o = ctl_q[6];
    assign cycle_slip_guard_select_o = ctl_q[8:7];
    assign cycle_slip_threshold_cycles_o = csp_cyc_q;
    assign pump_force_up_o = ctl_q[9];
    assign pump_force_down_o = ctl_q[10];
    assign pump_mid_rail_o = ctl_q[11];
    assign main_divider_clock_gating_o = ctl_q[13:12];
    assign exact_enable_o = en_q;
    assign exact_wrap_o = wrap_q;

    a_det_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_i && addr_i == `PDX_OFS_DET |=> det_q == $past(wdata_i))
        else $error("Detector word not stored.");
    a_det_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !(wr_i && addr_i == `PDX_OFS_DET) |=> $stable(det_q))
        else $error("Detector word changed without write.");
    a_read_data: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        rd_i && addr_i == `PDX_OFS_EXACT && !wr_i |=> rdata_o == exact_q)
        else $error("Wrong read data.");
    a_delay_out: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 detector_reset_delay_select_o == $past(det_q[2:0]))
        else $error("Delay select mismatch.");
    a_short_out: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 detector_inputs_short_o == $past(det_q[3]))
        else $error("Short control mismatch.");
    a_invert_out: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 detector_polarity_invert_o == $past(det_q[4]))
        else $error("Polarity mismatch.");
    a_up_enable: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 detector_up_output_enable_o == $past(det_q[5]))
        else $error("Up enable mismatch.");
    a_dn_enable: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 detector_down_output_enable_o == $past(det_q[6]))
        else $error("Down enable mismatch.");
    a_csp_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cycle_slip_guard_select_o == 2'h0 |-> cycle_slip_threshold_cycles_o == 16'h0000)
        else $error("Slip guard not disabled.");
    a_force_up: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 pump_force_up_o == $past(det_q[9]))
        else $error("Force up mismatch.");
    a_force_dn: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 pump_force_down_o == $past(det_q[10]))
        else $error("Force down mismatch.");
    a_mid_rail: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 pump_mid_rail_o == $past(det_q[11]))
        else $error("Mid rail mismatch.");
    a_gate_out: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 main_divider_clock_gating_o == $past(det_q[18:17]))
        else $error("Gating level mismatch.");
    a_exact_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        exact_q[13:1] == 13'h0000 |=> !exact_enable_o)
        else $error("Correction enabled for count below two.");
    a_wrap_needs_en: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        exact_wrap_o |-> $past(en_q, 2))
        else $error("Wrap while disabled.");
endmodule : pdx_detector_regs
`default_nettype wire

// *** verilog/pdx_defines.svh ***
// Register offsets, field positions, reset values and timing constants of the detector register bank.
`ifndef PDX_DEFINES_SVH
`define PDX_DEFINES_SVH
`define PDX_ADDR_W 8
`define PDX_DATA_W 24
`define PDX_OFS_DET 8'h0B
`define PDX_OFS_EXACT 8'h0C
`define PDX_OFS_STATUS 8'h0D
`define PDX_RST_DET 24'h07C061
`define PDX_RST_EXACT 24'h000000
`define PDX_DET_WMASK 24'hFFFFFF
`define PDX_EXACT_WMASK 24'h003FFF
`define PDX_F_DELAY_LSB 0
`define PDX_F_DELAY_MSB 2
`define PDX_F_SHORT 3
`define PDX_F_INVERT 4
`define PDX_F_UP_EN 5
`define PDX_F_DN_EN 6
`define PDX_F_CSP_LSB 7
`define PDX_F_CSP_MSB 8
`define PDX_F_FORCE_UP 9
`define PDX_F_FORCE_DN 10
`define PDX_F_MID_RAIL 11
`define PDX_F_GATE_LSB 17
`define PDX_F_GATE_MSB 18
`define PDX_F_CHAN_MSB 13
`define PDX_CLK_PS 40000
`define PDX_CSP1_PS 5400
`define PDX_CSP2_PS 14400
`define PDX_CSP3_PS 24100
`define PDX_CHAN_MIN 14'h0002
`endif

// *** verilog/pdx_pkg.sv ***
// Types shared by the detector register bank modules.
package pdx_pkg;
    typedef enum logic [1:0] {
        PDX_CSP_OFF = 2'h0,
        PDX_CSP_T1 = 2'h1,
        PDX_CSP_T2 = 2'h2,
        PDX_CSP_T3 = 2'h3
    } pdx_csp_type;
    typedef enum logic [1:0] {
        PDX_GATE_OFF = 2'h0,
        PDX_GATE_N128 = 2'h1,
        PDX_GATE_N1023 = 2'h2,
        PDX_GATE_ALL = 2'h3
    } pdx_gate_type;
    typedef enum logic [2:0] {
        PDX_ACC_IDLE = 3'h1,
        PDX_ACC_RUN = 3'h2,
        PDX_ACC_HOLD = 3'h4
    } pdx_acc_type;
endpackage : pdx_pkg

// *** verilog/pdx_regif.sv ***
// Interface carrying the programmed fields from the register bank to the correction core.
`timescale 1ns/10ps
`default_nettype none
interface pdx_regif;
    logic [13:0] chan_count;
    logic enable;
    logic wrap_pulse;
    logic [13:0] phase;
    modport bank (output chan_count, output enable, input wrap_pulse, input phase);
    modport core (input chan_count, input enable, output wrap_pulse, output phase);
endinterface : pdx_regif
`default_nettype wire

// *** verilog/pdx_exact_core.sv ***
// Exact-frequency correction sequencer: counts comparison cycles modulo the channel count.
`timescale 1ns/10ps
`default_nettype none
`include "pdx_defines.svh"
module pdx_exact_core (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    pdx_regif.core rif
);
    pdx_pkg::pdx_acc_type state_q;
    pdx_pkg::pdx_acc_type state_d;
    logic [13:0] phase_q;
    logic [13:0] phase_d;
    logic wrap_q;
    logic wrap_d;

    // Next state: run only while enabled, restart the phase count on every wrap.
    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        wrap_d = 1'b0;
        case (state_q)
            pdx_pkg::PDX_ACC_IDLE: begin
                phase_d = 14'h0000;
                if (rif.enable) begin
                    state_d = pdx_pkg::PDX_ACC_RUN;
                end
            end
            pdx_pkg::PDX_ACC_RUN: begin
                if (!rif.enable) begin
                    state_d = pdx_pkg::PDX_ACC_HOLD;
                end else if (phase_q >= rif.chan_count - 14'h0001) begin
                    phase_d = 14'h0000;
                    wrap_d = 1'b1;
                end else begin
                    phase_d = phase_q + 14'h0001;
                end
            end
            pdx_pkg::PDX_ACC_HOLD: begin
                state_d = pdx_pkg::PDX_ACC_IDLE;
                phase_d = 14'h0000;
            end
            default: begin
                state_d = pdx_pkg::PDX_ACC_IDLE;
                phase_d = 14'h0000;
            end
        endcase
    end

    // Registers of the sequencer.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= pdx_pkg::PDX_ACC_IDLE;
            phase_q <= 14'h0000;
            wrap_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            wrap_q <= wrap_d;
        end
    end

    assign rif.wrap_pulse = wrap_q;
    assign rif.phase = phase_q;

    a_wrap_period: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wrap_q |-> phase_q == 14'h0000)
        else $error("Wrap pulse without phase restart.");
endmodule : pdx_exact_core
`default_nettype wire

// *** tb/pdx_detector_regs_tb_top.sv ***
// Self-checking testbench of the detector control and exact-frequency register bank.
`timescale 1ns/10ps
`default_nettype none
`include "pdx_defines.svh"
module pdx_detector_regs_tb_top;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [23:0] wdata_i = 24'h000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [23:0] rdata_o;
    logic [2:0] dly;
    logic shrt, inv, upen, dnen, fup, fdn, mid, xen, xwrap;
    logic [1:0] csp, gate;
    logic [15:0] thr;
    int num_errors = 0;
    int n_checks = 0;

    // A 40 ns clock; reset is released after eight cycles.
    always #20 mclk_i = ~mclk_i;

    pdx_detector_regs i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .detector_reset_delay_select_o(dly),
        .detector_inputs_short_o(shrt), .detector_polarity_invert_o(inv), .detector_up_output_enable_o(upen),
        .detector_down_output_enable_o(dnen), .cycle_slip_guard_select_o(csp),
        .cycle_slip_threshold_cycles_o(thr), .pump_force_up_o(fup), .pump_force_down_o(fdn),
        .pump_mid_rail_o(mid), .main_divider_clock_gating_o(gate), .exact_enable_o(xen),
        .exact_wrap_o(xwrap));

    // Case inequality keeps an unknown from passing as a match.
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // One-cycle write strobe; returns right after the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Read data is looked at only in the cycle after the strobe, and must be zero after that.
    task automatic rd(input logic [7:0] a, input logic [23:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        chk(rdata_o, exp);
        @(negedge mclk_i);
        chk(rdata_o, 24'h000000);
    endtask : rd

    // Decoded outputs settle one edge after the write edge.
    task automatic check_det(input logic [23:0] d);
        repeat (3) @(negedge mclk_i);
        chk({21'h0, dly}, {21'h0, d[2:0]});
        chk({23'h0, shrt}, {23'h0, d[3]});
        chk({23'h0, inv}, {23'h0, d[4]});
        chk({23'h0, upen}, {23'h0, d[5]});
        chk({23'h0, dnen}, {23'h0, d[6]});
        chk({22'h0, csp}, {22'h0, d[8:7]});
        chk({8'h0, thr}, (d[8:7] == 2'h0) ? 24'h000000 : 24'h000001);
        chk({23'h0, fup}, {23'h0, d[9]});
        chk({23'h0, fdn}, {23'h0, d[10]});
        chk({23'h0, mid}, {23'h0, d[11]});
        chk({22'h0, gate}, {22'h0, d[18:17]});
    endtask : check_det

    // Reset defaults, seen both in the registers and on the decoded outputs.
    task automatic t_reset();
        check_det(24'h07C061);
        chk({23'h0, xen}, 24'h000000);
        rd(8'h0B, 24'h07C061);
        rd(8'h0C, 24'h000000);
    endtask : t_reset

    // All-ones, all-zeros and alternating patterns read back whole, then all cycle-slip codes and all gating levels.
    task automatic t_fields();
        logic [23:0] pats[4];
        pats = '{24'hFFFFFF, 24'h000000, 24'h555555, 24'hAAAAAA};
        foreach (pats[i]) begin
            wr(8'h0B, pats[i]);
            check_det(pats[i]);
            rd(8'h0B, pats[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h0B, {5'h00, i[1:0], 8'h00, i[1:0], 7'h21});
            check_det({5'h00, i[1:0], 8'h00, i[1:0], 7'h21});
        end
    endtask : t_fields

    // Unmapped and status writes leave both registers untouched; unmapped reads give zero.
    task automatic t_unmapped();
        wr(8'h0B, 24'h07C061);
        wr(8'h0C, 24'h000000);
        wr(8'h0A, 24'hFFFFFF);
        wr(8'h0D, 24'hFFFFFF);
        wr(8'h00, 24'h123456);
        rd(8'h00, 24'h000000);
        rd(8'h0A, 24'h000000);
        rd(8'h0B, 24'h07C061);
        rd(8'h0C, 24'h000000);
        check_det(24'h07C061);
    endtask : t_unmapped

    // Channel counts at both edges of the enabled range; upper bits never stick.
    task automatic t_exact();
        logic [13:0] vals[5];
        vals = '{14'h0000, 14'h0001, 14'h0002, 14'h3FFF, 14'h0000};
        foreach (vals[i]) begin
            wr(8'h0C, {10'h3FF, vals[i]});
            repeat (3) @(negedge mclk_i);
            chk({23'h0, xen}, {23'h0, vals[i] >= 14'h0002});
            rd(8'h0C, {10'h000, vals[i]});
        end
    endtask : t_exact

    // Wrap pulses must come exactly one channel count apart.
    task automatic t_wrap();
        int gap;
        wr(8'h0C, 24'h000005);
        for (int k = 0; k < 3; k++) begin
            gap = 0;
            @(negedge mclk_i);
            while (xwrap !== 1'b1 && gap < 40) begin
                @(negedge mclk_i);
                gap++;
            end
            if (k > 0) begin
                chk(gap[23:0], 24'h000004);
            end
        end
        wr(8'h0C, 24'h000000);
        repeat (4) @(negedge mclk_i);
        for (int k = 0; k < 12; k++) begin
            @(negedge mclk_i);
            chk({23'h0, xwrap}, 24'h000000);
        end
        rd(8'h0D, 24'h000000);
    endtask : t_wrap

    // Watchdog set well beyond the few hundred cycles the scenarios need.
    initial begin
        #(40 * 20000);
        num_errors++;
        close_out();
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_fields();
        t_unmapped();
        t_exact();
        t_wrap();
        close_out();
    end
endmodule : pdx_detector_regs_tb_top
`default_nettype wire
